// >>> osp_pkg.sv
package osp_pkg;
  // object dictionary subindices
  localparam logic [7:0]  SUB_COUNT   = 8'h00;
  localparam logic [7:0]  SUB_MODE    = 8'h01;
  localparam logic [7:0]  SUB_CYCLE   = 8'h02;
  localparam logic [7:0]  SUB_SHIFT   = 8'h03;
  localparam logic [7:0]  SUB_MODES   = 8'h04;
  localparam logic [7:0]  SUB_MINCYC  = 8'h05;
  localparam logic [7:0]  SUB_SPACING = 8'h06;
  localparam logic [7:0]  SUB_MEASURE = 8'h08;
  localparam logic [7:0]  SUB_MAXDLY  = 8'h09;
  localparam logic [7:0]  SUB_MISSED  = 8'h0b;
  localparam logic [7:0]  SUB_OVERRUN = 8'h0c;
  localparam logic [7:0]  SUB_SHORT   = 8'h0d;
  localparam logic [7:0]  SUB_SYNCERR = 8'h20;
  localparam logic [7:0]  ENTRY_COUNT = 8'h20;
  // sync modes
  localparam logic [15:0] MODE_FREE   = 16'h0000;
  localparam logic [15:0] MODE_SM2    = 16'h0001;
  localparam logic [15:0] MODE_SYNC0  = 16'h0002;
  localparam logic [15:0] MODE_SYNC1  = 16'h0003;
  // reset values
  localparam logic [31:0] CYCLE_RST   = 32'h000f4240;
  localparam logic [31:0] MINCYC_RST  = 32'h000186a0;
  localparam logic [31:0] ZERO_NS     = 32'h00000000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  // supported-modes mask layout
  localparam int          BIT_FREE    = 0;
  localparam int          BIT_SM2     = 1;
  localparam int          BIT_DC_LO   = 2;
  localparam int          BIT_SH_LO   = 4;
  localparam int          BIT_DYN     = 14;
  localparam logic [1:0]  DC_CODE     = 2'b01;
  localparam logic [1:0]  SHIFT_CODE  = 2'b10;
  // clock
  localparam int          CLK_PERIOD_NS = 10;
  localparam logic [31:0] CLK_STEP_NS   = 32'(CLK_PERIOD_NS);
  // error counter slots
  localparam int          CNT_MISSED  = 0;
  localparam int          CNT_OVERRUN = 1;
  localparam int          CNT_SHORT   = 2;
  localparam int          NUM_CNT     = 3;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [7:0]  subidx;
    logic [31:0] wdata;
  } osp_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } osp_od_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } osp_state_t;
endpackage

// >>> osp_output_sync.sv
// What this block does
// - sync mode word 0 free run, 1 sm2 event, 2 sync0, 3 sync1; resets free.
// - free run uses cycle time in ns as local timer period, default 1000000.
// - sm2 mode takes cycle time as master period; master sets it to match.
// - dc mode takes cycle time as sync0/sync1 pulse period.
// - read-only shift delay from sync0 to outputs, default zero.
// - read-only supported mask; bit0 free run, bit1 sm2; default one.
// - mask bits 2-3 = 01 dc capable, bits 4-5 = 10 sync1 shift.
// - mask bit 14 marks dynamic timing, measured on measurement subentry write.
// - read-only minimum cycle period, default 100000 ns.
// - read-only minimum sync0 to sync1 spacing in ns.
// - read-only delay from sync1 to outputs, default zero.
// - operational dc mode counts missed sm events, 16 bits from zero.
// - operational mode counts cycle overruns, 16 bits from zero.
// - dc mode counts sync0 to sync1 gaps shorter than required.
// - dc mode flag set on late output, cleared on good cycle.
`timescale 1ns/100ps
module osp_output_sync #(
  parameter logic        SUPPORT_SM2   = 1'b0,
  parameter logic        SUPPORT_DC    = 1'b0,
  parameter logic        SUPPORT_SHIFT = 1'b0,
  parameter logic        SUPPORT_DYN   = 1'b0,
  parameter logic [31:0] SHIFT_NS      = 32'h00000000,
  parameter logic [31:0] MINCYC_NS     = 32'h000186a0,
  parameter logic [31:0] SPACING_NS    = 32'h00000000,
  parameter logic [31:0] MAXDLY_NS     = 32'h00000000
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire osp_pkg::osp_od_req_t od_req_i,
  output osp_pkg::osp_od_rsp_t     od_rsp_o,
  input  wire logic                op_state_i,
  input  wire logic                cycle_done_i,
  input  wire logic                sm2_event_i,
  input  wire logic                sync0_i,
  input  wire logic                sync1_i,
  output logic                     apply_o,
  output logic                     measure_o,
  output logic [15:0]              sync_mode_o,
  output logic [31:0]              cycle_period_o,
  output logic                     late_output_o
);

  logic [2:0]          pin_meta;
  logic [2:0]          pin_sync;
  logic [2:0]          pin_prev;
  logic [15:0]         sync_mode;
  logic [31:0]         cycle_period;
  logic [31:0]         ns_cnt;
  logic [31:0]         gap_ns;
  logic                sm2_seen;
  logic                late;
  osp_pkg::osp_state_t state;
  logic [15:0]         err_cnt [osp_pkg::NUM_CNT];
  logic [osp_pkg::NUM_CNT-1:0] err_inc;

  // pin synchronisers: sm2, sync0, sync1
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_meta <= {sync1_i, sync0_i, sm2_event_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire sm2_edge = pin_sync[0] & ~pin_prev[0];
  wire s0_edge  = pin_sync[1] & ~pin_prev[1];
  wire s1_edge  = pin_sync[2] & ~pin_prev[2];

  // mode decode
  wire mode_free  = (sync_mode == osp_pkg::MODE_FREE);
  wire mode_sm2   = (sync_mode == osp_pkg::MODE_SM2);
  wire mode_sync0 = (sync_mode == osp_pkg::MODE_SYNC0);
  wire mode_sync1 = (sync_mode == osp_pkg::MODE_SYNC1);
  wire mode_dc    = mode_sync0 | mode_sync1;

  // supported-modes mask
  wire [15:0] modes_mask = (16'h0001 << osp_pkg::BIT_FREE)
    | (16'(SUPPORT_SM2) << osp_pkg::BIT_SM2)
    | (SUPPORT_DC ? (16'(osp_pkg::DC_CODE) << osp_pkg::BIT_DC_LO)
                  : 16'h0000)
    | (SUPPORT_SHIFT ? (16'(osp_pkg::SHIFT_CODE) << osp_pkg::BIT_SH_LO)
                     : 16'h0000)
    | (16'(SUPPORT_DYN) << osp_pkg::BIT_DYN);

  // local timer in ns
  wire [32:0] ns_sum  = {1'b0, ns_cnt} + {1'b0, osp_pkg::CLK_STEP_NS};
  wire        tick    = mode_free & (ns_sum >= {1'b0, cycle_period});
  wire [32:0] gap_sum = {1'b0, gap_ns} + {1'b0, osp_pkg::CLK_STEP_NS};

  // cycle start per mode
  wire apply_evt = (tick)
                 | (mode_sm2 & sm2_edge)
                 | (mode_sync0 & s0_edge)
                 | (mode_sync1 & s1_edge);

  wire busy     = (state == osp_pkg::ST_BUSY);
  wire overrun  = op_state_i & apply_evt & busy & ~cycle_done_i;
  wire missed   = op_state_i & mode_dc & s0_edge & ~sm2_seen & ~sm2_edge;
  wire short_gp = mode_dc & s1_edge & (gap_ns < SPACING_NS);

  assign err_inc[osp_pkg::CNT_MISSED]  = missed;
  assign err_inc[osp_pkg::CNT_OVERRUN] = overrun;
  assign err_inc[osp_pkg::CNT_SHORT]   = short_gp;

  // access decode
  wire req_go  = od_req_i.sel & (od_req_i.wr | od_req_i.rd);
  wire wr_go   = od_req_i.sel & od_req_i.wr;
  wire [15:0] wr_mode = od_req_i.wdata[15:0];
  wire mode_ok = (wr_mode == osp_pkg::MODE_FREE)
               | ((wr_mode == osp_pkg::MODE_SM2) & SUPPORT_SM2)
               | (((wr_mode == osp_pkg::MODE_SYNC0)
                 | (wr_mode == osp_pkg::MODE_SYNC1)) & SUPPORT_DC);
  wire cyc_ok  = (od_req_i.wdata >= MINCYC_NS);
  wire wr_mode_go  = wr_go & (od_req_i.subidx == osp_pkg::SUB_MODE)
                   & mode_ok;
  wire wr_cycle_go = wr_go & (od_req_i.subidx == osp_pkg::SUB_CYCLE)
                   & cyc_ok;
  wire wr_meas_go  = wr_go & (od_req_i.subidx == osp_pkg::SUB_MEASURE)
                   & SUPPORT_DYN;

  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = osp_pkg::ZERO_NS;
    rd_hit = 1'b1;
    case (od_req_i.subidx)
      osp_pkg::SUB_COUNT:   rd_val = 32'(osp_pkg::ENTRY_COUNT);
      osp_pkg::SUB_MODE:    rd_val = 32'(sync_mode);
      osp_pkg::SUB_CYCLE:   rd_val = cycle_period;
      osp_pkg::SUB_SHIFT:   rd_val = SHIFT_NS;
      osp_pkg::SUB_MODES:   rd_val = 32'(modes_mask);
      osp_pkg::SUB_MINCYC:  rd_val = MINCYC_NS;
      osp_pkg::SUB_SPACING: rd_val = SPACING_NS;
      osp_pkg::SUB_MEASURE: rd_hit = SUPPORT_DYN;
      osp_pkg::SUB_MAXDLY:  rd_val = MAXDLY_NS;
      osp_pkg::SUB_MISSED:  rd_val = 32'(err_cnt[osp_pkg::CNT_MISSED]);
      osp_pkg::SUB_OVERRUN: rd_val = 32'(err_cnt[osp_pkg::CNT_OVERRUN]);
      osp_pkg::SUB_SHORT:   rd_val = 32'(err_cnt[osp_pkg::CNT_SHORT]);
      osp_pkg::SUB_SYNCERR: rd_val = 32'(late);
      default:              rd_hit = 1'b0;
    endcase
  end

  // writes to read-only entries are acked and dropped
  wire bad_wr = wr_go & (((od_req_i.subidx == osp_pkg::SUB_MODE) & ~mode_ok)
              | ((od_req_i.subidx == osp_pkg::SUB_CYCLE) & ~cyc_ok));
  wire abort  = req_go & (~rd_hit | bad_wr);

  // writable entries
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_mode    <= osp_pkg::MODE_FREE;
      cycle_period <= osp_pkg::CYCLE_RST;
    end else begin
      if (wr_mode_go)
        sync_mode <= wr_mode;
      if (wr_cycle_go)
        cycle_period <= od_req_i.wdata;
    end
  end

  // access answer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      od_rsp_o  <= '0;
      measure_o <= 1'b0;
    end else begin
      od_rsp_o.ack   <= req_go;
      od_rsp_o.abort <= abort;
      od_rsp_o.rdata <= (req_go & od_req_i.rd & rd_hit) ? rd_val
                                                         : osp_pkg::ZERO_NS;
      measure_o      <= wr_meas_go;
    end
  end

  // timers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ns_cnt <= osp_pkg::ZERO_NS;
      gap_ns <= osp_pkg::ZERO_NS;
    end else begin
      ns_cnt <= (tick | ~mode_free) ? osp_pkg::ZERO_NS : ns_sum[31:0];
      if (s0_edge)
        gap_ns <= osp_pkg::ZERO_NS;
      else if (!gap_sum[32])
        gap_ns <= gap_sum[31:0];
    end
  end

  // cycle tracking
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= osp_pkg::ST_IDLE;
      sm2_seen <= 1'b0;
      late     <= 1'b0;
      apply_o  <= 1'b0;
    end else begin
      apply_o  <= apply_evt;
      sm2_seen <= sm2_edge | (sm2_seen & ~s0_edge);
      if (mode_dc & apply_evt)
        late <= busy & ~cycle_done_i;
      case (state)
        osp_pkg::ST_IDLE: if (apply_evt) state <= osp_pkg::ST_BUSY;
        osp_pkg::ST_BUSY: if (cycle_done_i & ~apply_evt)
                            state <= osp_pkg::ST_IDLE;
        default:          state <= osp_pkg::ST_IDLE;
      endcase
    end
  end

  // saturating error counters
  for (genvar i = 0; i < osp_pkg::NUM_CNT; i++) begin : g_cnt
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
        err_cnt[i] <= osp_pkg::CNT_RST;
      else if (err_inc[i] && err_cnt[i] != osp_pkg::CNT_MAX)
        err_cnt[i] <= err_cnt[i] + 16'h0001;
    end
  end

  assign sync_mode_o    = sync_mode;
  assign cycle_period_o = cycle_period;
  assign late_output_o  = late;

  property p_mode_keep;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wr_go && od_req_i.subidx == osp_pkg::SUB_MODE && !mode_ok)
      |=> $stable(sync_mode);
  endproperty
  a_mode_keep: assert property (p_mode_keep)
    else $error("unsupported mode was taken");

  property p_free_apply;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_free && ns_sum >= {1'b0, cycle_period}) |=> apply_o && ns_cnt == 0;
  endproperty
  a_free_apply: assert property (p_free_apply)
    else $error("free run timer did not expire at period");

  property p_sm2_apply;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_sm2 && pin_sync[0] && !pin_prev[0]) |=> apply_o;
  endproperty
  a_sm2_apply: assert property (p_sm2_apply)
    else $error("sm2 event did not apply outputs");

  property p_dc_apply;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_sync1 && $rose(pin_sync[2])) |=> apply_o;
  endproperty
  a_dc_apply: assert property (p_dc_apply)
    else $error("sync1 pulse did not apply outputs");

  property p_rd_mask;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (od_req_i.sel && od_req_i.rd && od_req_i.subidx == osp_pkg::SUB_MODES)
      |=> od_rsp_o.ack && od_rsp_o.rdata[osp_pkg::BIT_FREE]
          && od_rsp_o.rdata[osp_pkg::BIT_SM2] == SUPPORT_SM2;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("supported mask read wrong");

  property p_rd_mincyc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (od_req_i.sel && od_req_i.rd && od_req_i.subidx == osp_pkg::SUB_MINCYC)
      |=> od_rsp_o.rdata == MINCYC_NS;
  endproperty
  a_rd_mincyc: assert property (p_rd_mincyc)
    else $error("minimum cycle read wrong");

  property p_missed;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (missed && err_cnt[osp_pkg::CNT_MISSED] != osp_pkg::CNT_MAX)
      |=> err_cnt[osp_pkg::CNT_MISSED]
          == $past(err_cnt[osp_pkg::CNT_MISSED]) + 16'h0001;
  endproperty
  a_missed: assert property (p_missed)
    else $error("missed event not counted");

  property p_overrun_op;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !op_state_i |=> $stable(err_cnt[osp_pkg::CNT_OVERRUN]);
  endproperty
  a_overrun_op: assert property (p_overrun_op)
    else $error("overrun counted outside operational");

  property p_short;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !mode_dc |=> $stable(err_cnt[osp_pkg::CNT_SHORT]);
  endproperty
  a_short: assert property (p_short)
    else $error("short gap counted outside dc mode");

  property p_late;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_dc && apply_evt && !busy) |=> !late_output_o;
  endproperty
  a_late: assert property (p_late)
    else $error("sync error not cleared on good cycle");

  property p_sat;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (err_cnt[osp_pkg::CNT_OVERRUN] == osp_pkg::CNT_MAX)
      |=> err_cnt[osp_pkg::CNT_OVERRUN] == osp_pkg::CNT_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("error counter wrapped");

endmodule

// >>> osp_master_model.sv
`timescale 1ns/100ps
module osp_master_model (
  input  wire logic sys_clk_i,
  output logic      sm2_event_o,
  output logic      sync0_o,
  output logic      sync1_o,
  output logic      cycle_done_o
);
  initial begin
    sm2_event_o  = 1'b0;
    sync0_o      = 1'b0;
    sync1_o      = 1'b0;
    cycle_done_o = 1'b0;
  end

  // one event on a line: 4 clocks high, 4 low; lines idle low
  task automatic pulse(input int sel);
    @(posedge sys_clk_i);
    #1;
    case (sel)
      0: sm2_event_o = 1'b1;
      1: sync0_o = 1'b1;
      2: sync1_o = 1'b1;
      default: cycle_done_o = 1'b1;
    endcase
    repeat (4) @(posedge sys_clk_i);
    #1;
    sm2_event_o  = 1'b0;
    sync0_o      = 1'b0;
    sync1_o      = 1'b0;
    cycle_done_o = 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // sync1 two clocks after sync0
  task automatic pair();
    @(posedge sys_clk_i);
    #1;
    sync0_o = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    sync1_o = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    sync0_o = 1'b0;
    sync1_o = 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule

// >>> tb_output_sync_parameters.sv
`timescale 1ns/100ps
module tb_output_sync_parameters;
  localparam logic [31:0] SHIFT   = 32'h00000000;
  localparam logic [31:0] MINCYC  = 32'h000186a0;
  localparam logic [31:0] SPACING = 32'h00000064;
  localparam logic [31:0] MAXDLY  = 32'h00000000;
  localparam logic [31:0] MASK    = 32'h00004027;
  logic                 sys_clk_i = 1'b0;
  logic                 rst_n_i   = 1'b0;
  logic                 op_state  = 1'b0;
  osp_pkg::osp_od_req_t od_req    = '0;
  osp_pkg::osp_od_rsp_t od_rsp;
  logic                 sm2, sync0, sync1, cdone, apply, measure, late;
  logic [15:0]          mode;
  logic [31:0]          period;
  logic [31:0]          rd;
  int                   mismatches = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  int                   last_ap = 0;
  int                   gap = 0;
  int                   n_apply = 0;
  int                   n_meas = 0;
  int                   n;

  always #5 sys_clk_i = ~sys_clk_i;

  osp_master_model u_m (.sys_clk_i(sys_clk_i), .sm2_event_o(sm2),
    .sync0_o(sync0), .sync1_o(sync1), .cycle_done_o(cdone));

  osp_output_sync #(.SUPPORT_SM2(1'b1), .SUPPORT_DC(1'b1),
    .SUPPORT_SHIFT(1'b1), .SUPPORT_DYN(1'b1),
    .SPACING_NS(SPACING)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .od_req_i(od_req),
    .od_rsp_o(od_rsp), .op_state_i(op_state), .cycle_done_i(cdone),
    .sm2_event_i(sm2), .sync0_i(sync0), .sync1_i(sync1),
    .apply_o(apply), .measure_o(measure), .sync_mode_o(mode),
    .cycle_period_o(period), .late_output_o(late));

  always @(posedge sys_clk_i) begin
    cyc++;
    if (apply === 1'b1) begin
      gap = cyc - last_ap;
      last_ap = cyc;
      n_apply++;
    end
    if (measure === 1'b1) begin
      n_meas++;
    end
    if (cyc == 25000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  // one access: request held over one edge, answer seen just after that same edge
  task automatic od(input logic w, input logic [7:0] sub,
                    input logic [31:0] wd, input logic ab);
    @(posedge sys_clk_i);
    #1;
    od_req = '{sel: 1'b1, wr: w, rd: ~w, subidx: sub, wdata: wd};
    @(posedge sys_clk_i);
    #1;
    od_req = '0;
    chk({31'h0, od_rsp.ack}, 32'h1, "ack");
    chk({31'h0, od_rsp.abort}, {31'h0, ab}, "abort");
    rd = od_rsp.rdata;
  endtask

  task automatic t_reset();
    logic [7:0]  subs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                               8'h06, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20};
    logic [31:0] exps [12] = '{32'h20, 32'h0, 32'h000f4240, SHIFT, MASK,
                               MINCYC, SPACING, MAXDLY, 32'h0, 32'h0,
                               32'h0, 32'h0};
    for (int i = 0; i < 12; i++) begin
      od(1'b0, subs[i], 32'h0, 1'b0);
      chk(rd, exps[i], "reset value");
    end
    od(1'b0, 8'h07, 32'h0, 1'b1);
    $display("test reset values done");
  endtask

  task automatic t_access();
    od(1'b1, 8'h04, 32'h0, 1'b0);
    od(1'b0, 8'h04, 32'h0, 1'b0);
    chk(rd, MASK, "read-only kept");
    od(1'b1, 8'h01, 32'h4, 1'b1);
    for (int m = 0; m < 4; m++) begin
      od(1'b1, 8'h01, 32'(m), 1'b0);
      chk({16'h0, mode}, 32'(m), "mode out");
      od(1'b0, 8'h01, 32'h0, 1'b0);
      chk(rd, 32'(m), "mode read");
    end
    $display("test access done");
  endtask

  task automatic t_freerun();
    od(1'b1, 8'h01, 32'h0, 1'b0);
    od(1'b1, 8'h02, MINCYC, 1'b0);
    chk(period, MINCYC, "period");
    od(1'b1, 8'h02, 32'h32, 1'b1);
    chk(period, MINCYC, "short period refused");
    repeat (20020) @(posedge sys_clk_i);
    chk(32'(gap), 32'h00002710, "free-run spacing");
    $display("test free run done");
  endtask

  task automatic t_sm2();
    od(1'b1, 8'h01, 32'h1, 1'b0);
    repeat (12) @(posedge sys_clk_i);
    n = n_apply;
    u_m.pulse(1);
    chk(32'(n_apply), 32'(n), "sync0 ignored");
    u_m.pulse(0);
    chk(32'(n_apply), 32'(n + 1), "sm2 apply");
    $display("test sm2 done");
  endtask

  task automatic t_dc();
    od(1'b1, 8'h01, 32'h2, 1'b0);
    u_m.pulse(3);
    #1;
    op_state = 1'b1;
    n = n_apply;
    u_m.pulse(0);
    u_m.pulse(1);
    u_m.pulse(1);
    chk(32'(n_apply), 32'(n + 2), "sync0 applies");
    chk({31'h0, late}, 32'h1, "late set");
    u_m.pulse(3);
    u_m.pulse(0);
    u_m.pair();
    chk({31'h0, late}, 32'h0, "late cleared");
    u_m.pulse(2);
    od(1'b0, 8'h0b, 32'h0, 1'b0);
    chk(rd, 32'h1, "missed count");
    od(1'b0, 8'h0c, 32'h0, 1'b0);
    chk(rd, 32'h1, "overrun count");
    od(1'b0, 8'h0d, 32'h0, 1'b0);
    chk(rd, 32'h1, "short count");
    od(1'b0, 8'h20, 32'h0, 1'b0);
    chk(rd, 32'h0, "sync error");
    op_state = 1'b0;
    od(1'b1, 8'h01, 32'h3, 1'b0);
    n = n_apply;
    u_m.pulse(1);
    chk(32'(n_apply), 32'(n), "sync0 ignored in sync1 mode");
    u_m.pulse(2);
    chk(32'(n_apply), 32'(n + 1), "sync1 applies");
    $display("test dc done");
  endtask

  task automatic t_rerst();
    @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk({16'h0, mode}, 32'h0, "mode after reset");
    chk(period, 32'h000f4240, "period after reset");
    chk({31'h0, late}, 32'h0, "late after reset");
    od(1'b0, 8'h0b, 32'h0, 1'b0);
    chk(rd, 32'h0, "missed after reset");
    $display("test mid-run reset done");
  endtask

  task automatic t_measure();
    n = n_meas;
    od(1'b1, 8'h08, 32'h0, 1'b0);
    repeat (3) @(posedge sys_clk_i);
    chk(32'(n_meas), 32'(n + 1), "measure pulse");
    $display("test measure done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_access();
    t_freerun();
    t_sm2();
    t_dc();
    t_measure();
    t_rerst();
    final_report();
  end
endmodule
